/* File: usb_descriptor_rom.sv */
// Purpose: Serves device and configuration descriptors byte by byte.
// Assumes: Requests come decoded from the control endpoint setup stage.
// Notes: Bytes leave on a valid/ready stream; ce low freezes all state.
`timescale 1ns/1ps
module usb_descriptor_rom
  import usb_desc_pkg::*;
#(
  parameter logic [15:0] VENDOR_ID_DEF = 16'h1111, // Arbitrary value
  parameter logic [15:0] PRODUCT_ID_DEF = 16'h2222 // Arbitrary value
) (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic ce,
  input wire logic req_valid,
  input wire desc_req_t req,
  output logic req_ready,
  output logic req_stall,
  input wire logic high_speed,
  input wire logic [7:0] network_control_reg,
  input wire eeprom_cfg_t eeprom,
  output logic tx_valid,
  output logic [7:0] tx_byte,
  output logic tx_last,
  input wire logic tx_ready
);

  // Sequencer and output registers
  seq_state_t state_reg; // Current state
  seq_state_t state_next; // Next state
  logic [5:0] pos_reg; // Index of byte on tx_byte
  logic [5:0] limit_reg; // Bytes to send this transfer
  logic kind_dev_reg; // High for device, low for config set
  logic req_ready_reg;
  logic req_stall_reg;
  logic tx_valid_reg;
  logic [7:0] tx_byte_reg;
  logic tx_last_reg;

  // Decode and image signals
  logic dev_ok; // Device descriptor requested
  logic cfg_ok; // Configuration set requested
  logic [5:0] req_size; // Full size of requested image
  logic [5:0] req_lim; // Size clipped to host length
  logic accept; // Request taken this cycle
  logic fire; // Byte taken by consumer this cycle
  logic rd_dev; // Image selector for next byte
  logic [5:0] rd_idx; // Index of next byte
  logic [7:0] rd_byte; // Next byte from the image
  logic [15:0] vendor_id;
  logic [15:0] product_id;
  logic [7:0] max_power;
  logic [7:0] bulk_interval;
  logic [15:0] bulk_mps;
  logic [7:0] cfg_attr;
  dev_image_t dev_img;
  cfg_image_t cfg_img;
  ep_image_t ep1_img;
  ep_image_t ep2_img;
  ep_image_t ep3_img;

  // Memory-loaded fields fall back to defaults
  assign vendor_id = eeprom.present ? eeprom.vendor_id : VENDOR_ID_DEF;
  assign product_id = eeprom.present ? eeprom.product_id : PRODUCT_ID_DEF;
  assign max_power = eeprom.present ? eeprom.max_power : MAX_POWER_DEF;
  assign bulk_interval = eeprom.present ? eeprom.bulk_interval
                                        : BULK_INTERVAL_DEF;

  // Speed selects bulk packet size
  assign bulk_mps = high_speed ? MPS_HIGH : MPS_FULL;

  // Wake bit mirrors the network control bit
  assign cfg_attr = ATTR_BASE
                    | (network_control_reg[WAKE_SRC_BIT] ? ATTR_WAKE
                                                         : BYTE_ZERO);

  // Device descriptor image
  assign dev_img = {DEV_DESC_LEN, DT_DEVICE, BCD_USB[7:0], BCD_USB[15:8],
                    CLASS_NONE, CLASS_NONE, CLASS_NONE,
                    EP0_MAX_PACKET,
                    vendor_id[7:0], vendor_id[15:8],
                    product_id[7:0], product_id[15:8],
                    BCD_DEVICE[7:0], BCD_DEVICE[15:8],
                    STR_MANUF, STR_PRODUCT, STR_SERIAL, NUM_CONFIGS};

  // Endpoint images, bulk pair and interrupt endpoint
  usb_ep_desc #(.EP_ADDR(EP1_ADDR), .EP_ATTR(XFER_BULK)) u_ep1 (
    .max_packet(bulk_mps),
    .interval(bulk_interval),
    .image(ep1_img)
  );
  usb_ep_desc #(.EP_ADDR(EP2_ADDR), .EP_ATTR(XFER_BULK)) u_ep2 (
    .max_packet(bulk_mps),
    .interval(bulk_interval),
    .image(ep2_img)
  );
  usb_ep_desc #(.EP_ADDR(EP3_ADDR), .EP_ATTR(XFER_INTR)) u_ep3 (
    .max_packet(EP3_MPS),
    .interval(EP3_INTERVAL),
    .image(ep3_img)
  );

  // Whole configuration set in order
  assign cfg_img = {CFG_DESC_LEN, DT_CONFIG,
                    CFG_TOTAL_LEN[7:0], CFG_TOTAL_LEN[15:8],
                    NUM_INTERFACES, CONFIG_VALUE, STR_NONE,
                    cfg_attr, max_power,
                    INTF_DESC_LEN, DT_INTERFACE, INTF_NUMBER, ALT_SETTING,
                    NUM_ENDPOINTS, CLASS_NONE, CLASS_NONE, CLASS_NONE,
                    STR_NONE,
                    ep1_img, ep2_img, ep3_img};

  // Request decode and length clipping
  always_comb begin
    dev_ok = (req.desc_type == DT_DEVICE) && (req.desc_index == INDEX_ZERO);
    cfg_ok = (req.desc_type == DT_CONFIG) && (req.desc_index == INDEX_ZERO);
    req_size = dev_ok ? DEV_SIZE : CFG_SET_SIZE;
    if (req.length < {10'h000, req_size}) begin
      req_lim = req.length[5:0];
    end else begin
      req_lim = req_size;
    end
  end

  // Handshake terms, all gated by the clock enable
  assign accept = ce && req_valid && req_ready_reg;
  assign fire = ce && tx_valid_reg && tx_ready;

  // Byte lookup for the next value of tx_byte
  always_comb begin
    rd_dev = accept ? dev_ok : kind_dev_reg;
    rd_idx = accept ? POS_ZERO : pos_reg + POS_ONE;
    if (rd_dev) begin
      rd_byte = (rd_idx < DEV_SIZE) ? dev_img[rd_idx] : BYTE_ZERO;
    end else begin
      rd_byte = (rd_idx < CFG_SET_SIZE) ? cfg_img[rd_idx] : BYTE_ZERO;
    end
  end

  // Next state of the sequencer
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: begin
        // Unknown types and empty lengths never start a data stage
        if (accept && (dev_ok || cfg_ok) && (req_lim != POS_ZERO)) begin
          state_next = ST_SEND;
        end
      end
      ST_SEND: begin
        if (fire && tx_last_reg) begin
          state_next = ST_IDLE;
        end
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  // State and handshake flags
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      state_reg <= ST_IDLE;
      req_ready_reg <= 1'b0;
      tx_valid_reg <= 1'b0;
      req_stall_reg <= 1'b0;
    end else if (ce) begin
      state_reg <= state_next;
      req_ready_reg <= (state_next == ST_IDLE);
      tx_valid_reg <= (state_next == ST_SEND);
      // One-cycle refusal for unsupported requests
      req_stall_reg <= accept && !(dev_ok || cfg_ok);
    end
  end

  // Transfer bookkeeping captured on accept
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      limit_reg <= POS_ZERO;
      kind_dev_reg <= 1'b0;
    end else if (accept) begin
      limit_reg <= req_lim;
      kind_dev_reg <= dev_ok;
    end
  end

  // Byte position, data and last marker
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      pos_reg <= POS_ZERO;
      tx_byte_reg <= BYTE_ZERO;
      tx_last_reg <= 1'b0;
    end else if (accept) begin
      pos_reg <= POS_ZERO;
      tx_byte_reg <= rd_byte;
      tx_last_reg <= (req_lim == POS_ONE);
    end else if (fire) begin
      pos_reg <= pos_reg + POS_ONE;
      tx_byte_reg <= rd_byte;
      tx_last_reg <= (pos_reg + POS_TWO == limit_reg);
    end
  end

  // Outputs straight from registers
  assign req_ready = req_ready_reg;
  assign req_stall = req_stall_reg;
  assign tx_valid = tx_valid_reg;
  assign tx_byte = tx_byte_reg;
  assign tx_last = tx_last_reg;

  // Checks on the served bytes
  a_dev_header: assert property (@(posedge clock) disable iff (sys_rst)
    tx_valid_reg && kind_dev_reg && pos_reg == POS_ONE |-> tx_byte_reg == 8'h01)
    else $error("device type byte wrong");
  a_dev_class_zero: assert property (@(posedge clock) disable iff (sys_rst)
    tx_valid_reg && kind_dev_reg && pos_reg == 6'h04 |-> tx_byte_reg == 8'h00)
    else $error("device class not zero");
  a_ep0_size: assert property (@(posedge clock) disable iff (sys_rst)
    tx_valid_reg && kind_dev_reg && pos_reg == 6'h07 |-> tx_byte_reg == 8'h08)
    else $error("control packet size wrong");
  a_num_configs: assert property (@(posedge clock) disable iff (sys_rst)
    tx_valid_reg && kind_dev_reg && pos_reg == 6'h11 |-> tx_byte_reg == 8'h01)
    else $error("configuration count wrong");
  a_cfg_total: assert property (@(posedge clock) disable iff (sys_rst)
    tx_valid_reg && !kind_dev_reg && pos_reg == POS_TWO
      |-> tx_byte_reg == 8'h27)
    else $error("total length wrong");
  a_wake_attr: assert property (@(posedge clock) disable iff (sys_rst)
    accept && cfg_ok && req_lim > 6'h07 ##1 (fire [*7])
      |=> tx_byte_reg == ($past(network_control_reg[6]) ? 8'hA0 : 8'h80))
    else $error("attributes byte wrong");
  a_num_endpoints: assert property (@(posedge clock) disable iff (sys_rst)
    tx_valid_reg && !kind_dev_reg && pos_reg == 6'h0D
      |-> tx_byte_reg == 8'h03)
    else $error("endpoint count wrong");
  a_ep1_address: assert property (@(posedge clock) disable iff (sys_rst)
    tx_valid_reg && !kind_dev_reg && pos_reg == 6'h14
      |-> tx_byte_reg == 8'h81)
    else $error("endpoint 1 address wrong");
  a_ep2_address: assert property (@(posedge clock) disable iff (sys_rst)
    tx_valid_reg && !kind_dev_reg && pos_reg == 6'h1B
      |-> tx_byte_reg == 8'h02)
    else $error("endpoint 2 address wrong");
  a_bulk_size: assert property (@(posedge clock) disable iff (sys_rst)
    tx_valid_reg && !kind_dev_reg && pos_reg == 6'h17
      |-> tx_byte_reg == (high_speed ? 8'h02 : 8'h00))
    else $error("bulk size high byte wrong");
  a_length_bound: assert property (@(posedge clock) disable iff (sys_rst)
    tx_valid_reg |-> pos_reg < limit_reg
      && (tx_last_reg == (pos_reg + POS_ONE == limit_reg)))
    else $error("transfer runs past its length");
  a_answer_start: assert property (@(posedge clock) disable iff (sys_rst)
    accept && (dev_ok || cfg_ok) && req_lim != POS_ZERO
      |=> tx_valid_reg && pos_reg == POS_ZERO && !req_ready_reg)
    else $error("data stage did not start");

endmodule : usb_descriptor_rom

/* File: usb_desc_pkg.sv */
// Purpose: Shared constants and types for the descriptor source.
// Assumes: Little-endian word fields, byte 0 of each descriptor first.
// Notes: Byte images are packed arrays indexed from byte 0.
package usb_desc_pkg;

  // Descriptor type codes
  localparam logic [7:0] DT_DEVICE = 8'h01;
  localparam logic [7:0] DT_CONFIG = 8'h02;
  localparam logic [7:0] DT_INTERFACE = 8'h04;
  localparam logic [7:0] DT_ENDPOINT = 8'h05;

  // Descriptor lengths in bytes
  localparam logic [7:0] DEV_DESC_LEN = 8'h12;
  localparam logic [7:0] CFG_DESC_LEN = 8'h09;
  localparam logic [7:0] INTF_DESC_LEN = 8'h09;
  localparam logic [7:0] EP_DESC_LEN = 8'h07;
  localparam logic [15:0] CFG_TOTAL_LEN = 16'h0027;

  // Image sizes for indexing
  localparam int DEV_BYTES = 18;
  localparam int CFG_SET_BYTES = 39;
  localparam int EP_BYTES = 7;
  localparam logic [5:0] DEV_SIZE = 6'h12;
  localparam logic [5:0] CFG_SET_SIZE = 6'h27;

  // Device descriptor fields
  localparam logic [15:0] BCD_USB = 16'h0200;
  localparam logic [7:0] CLASS_NONE = 8'h00;
  localparam logic [7:0] EP0_MAX_PACKET = 8'h08;
  localparam logic [15:0] BCD_DEVICE = 16'h0101;
  localparam logic [7:0] STR_MANUF = 8'h01;
  localparam logic [7:0] STR_PRODUCT = 8'h02;
  localparam logic [7:0] STR_SERIAL = 8'h03;
  localparam logic [7:0] STR_NONE = 8'h00;
  localparam logic [7:0] NUM_CONFIGS = 8'h01;

  // Configuration and interface fields
  localparam logic [7:0] NUM_INTERFACES = 8'h01;
  localparam logic [7:0] CONFIG_VALUE = 8'h01;
  localparam logic [7:0] ATTR_BASE = 8'h80;
  localparam logic [7:0] ATTR_WAKE = 8'h20;
  localparam int WAKE_SRC_BIT = 6;
  localparam logic [7:0] MAX_POWER_DEF = 8'h3C;
  localparam logic [7:0] INTF_NUMBER = 8'h00;
  localparam logic [7:0] ALT_SETTING = 8'h00;
  localparam logic [7:0] NUM_ENDPOINTS = 8'h03;

  // Endpoint fields
  localparam logic [7:0] EP1_ADDR = 8'h81;
  localparam logic [7:0] EP2_ADDR = 8'h02;
  localparam logic [7:0] EP3_ADDR = 8'h83;
  localparam logic [7:0] XFER_BULK = 8'h02;
  localparam logic [7:0] XFER_INTR = 8'h03;
  localparam logic [15:0] MPS_FULL = 16'h0040;
  localparam logic [15:0] MPS_HIGH = 16'h0200;
  localparam logic [15:0] EP3_MPS = 16'h0008;
  localparam logic [7:0] BULK_INTERVAL_DEF = 8'h00;
  localparam logic [7:0] EP3_INTERVAL = 8'h01;

  // Request decode
  localparam logic [7:0] INDEX_ZERO = 8'h00;
  localparam logic [5:0] POS_ZERO = 6'h00;
  localparam logic [5:0] POS_ONE = 6'h01;
  localparam logic [5:0] POS_TWO = 6'h02;
  localparam logic [7:0] BYTE_ZERO = 8'h00;

  // Byte images
  typedef logic [0:DEV_BYTES-1][7:0] dev_image_t;
  typedef logic [0:CFG_SET_BYTES-1][7:0] cfg_image_t;
  typedef logic [0:EP_BYTES-1][7:0] ep_image_t;

  // Get-descriptor request as decoded from the setup stage
  typedef struct packed {
    logic [7:0] desc_type;
    logic [7:0] desc_index;
    logic [15:0] length;
  } desc_req_t;

  // Values loaded from the configuration memory
  typedef struct packed {
    logic present;
    logic [15:0] vendor_id;
    logic [15:0] product_id;
    logic [7:0] max_power;
    logic [7:0] bulk_interval;
  } eeprom_cfg_t;

  // Sequencer states, Gray along idle to send
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_SEND = 2'b01
  } seq_state_t;

endpackage : usb_desc_pkg

/* File: usb_ep_desc.sv */
// Purpose: Byte image of one endpoint descriptor.
// Assumes: Inputs are stable while the image is read.
// Notes: Purely combinational; the top registers its output.
`timescale 1ns/1ps
module usb_ep_desc
  import usb_desc_pkg::*;
#(
  parameter logic [7:0] EP_ADDR = 8'h00,
  parameter logic [7:0] EP_ATTR = 8'h00
) (
  input wire logic [15:0] max_packet,
  input wire logic [7:0] interval,
  output ep_image_t image
);

  // Length, type, address, attributes, size low/high, interval
  assign image = {EP_DESC_LEN, DT_ENDPOINT, EP_ADDR, EP_ATTR,
                  max_packet[7:0], max_packet[15:8], interval};

endmodule : usb_ep_desc

/* File: host_model.sv */
// Purpose: Host controller model that fetches descriptors from the block.
// Assumes: One request at a time; bytes are taken until the last one.
// Notes: Released request fields carry the inverse of their last value.
`timescale 1ns/1ps
module host_model
  import usb_desc_pkg::*;
(
  input wire logic clock,
  input wire logic ce,
  input wire logic req_ready,
  input wire logic req_stall,
  input wire logic tx_valid,
  input wire logic [7:0] tx_byte,
  input wire logic tx_last,
  output logic req_valid,
  output desc_req_t req,
  output logic tx_ready
);
  logic [7:0] got[$]; // Bytes taken during the last fetch
  logic stalled; // Last fetch was refused
  logic timed_out; // A bounded wait ran out

  // Quiet lines at time zero
  initial begin
    req_valid = 1'b0;
    req = '0;
    tx_ready = 1'b0;
    stalled = 1'b0;
    timed_out = 1'b0;
  end

  // Issue one request, hold it until taken, then gather the answer
  task automatic fetch(input logic [7:0] dtype, input logic [7:0] dindex,
      input logic [15:0] len, input logic slow);
    int n;
    got.delete();
    stalled = 1'b0;
    @(posedge clock);
    req_valid <= 1'b1;
    req <= '{desc_type: dtype, desc_index: dindex, length: len};
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (!(req_ready === 1'b1 && ce === 1'b1) && n < 200);
    req_valid <= 1'b0;
    req <= ~req; // Released fields no longer show the request
    if (n >= 200) begin
      timed_out = 1'b1;
      return;
    end
    tx_ready <= 1'b1;
    n = 0;
    forever begin
      @(posedge clock);
      n++;
      // Refusal shows one cycle after the take
      if (n == 1 && req_stall === 1'b1) begin
        stalled = 1'b1;
        break;
      end
      // Zero length: ready stays up, nothing sent
      if (n == 1 && req_ready === 1'b1 && tx_valid !== 1'b1) begin
        break;
      end
      if (tx_valid === 1'b1 && tx_ready === 1'b1 && ce === 1'b1) begin
        got.push_back(tx_byte);
        if (tx_last === 1'b1) begin
          break;
        end
      end
      if (n > 400) begin
        timed_out = 1'b1;
        break;
      end
      // Slow consumer stalls every other cycle
      if (slow) begin
        tx_ready <= ~tx_ready;
      end
    end
    tx_ready <= 1'b0;
  endtask : fetch
endmodule : host_model

/* File: testbench.sv */
// Purpose: Self-checking bench for the descriptor source.
// Assumes: Built-in identifier defaults left at their parameter values.
// Notes: Expected images are built here byte by byte, low byte first.
`timescale 1ns/1ps
module testbench;
  import usb_desc_pkg::*;
  typedef logic [7:0] byte_q_t[$];
  logic clock; // 200 MHz
  logic sys_rst; // Async reset, active high
  logic ce; // Clock enable
  logic high_speed; // Bus speed select
  logic [7:0] network_control_reg; // Bit 6 feeds the wake bit
  eeprom_cfg_t eeprom; // Loaded configuration values
  logic req_valid, req_ready, req_stall;
  desc_req_t req;
  logic tx_valid, tx_last, tx_ready;
  logic [7:0] tx_byte;
  int num_errors = 0;
  int tests_run = 0;

  usb_descriptor_rom usb_descriptor_rom_inst (.clock(clock),
    .sys_rst(sys_rst), .ce(ce), .req_valid(req_valid), .req(req),
    .req_ready(req_ready), .req_stall(req_stall), .high_speed(high_speed),
    .network_control_reg(network_control_reg), .eeprom(eeprom),
    .tx_valid(tx_valid), .tx_byte(tx_byte), .tx_last(tx_last),
    .tx_ready(tx_ready));
  host_model host_model_inst (.clock(clock), .ce(ce),
    .req_ready(req_ready), .req_stall(req_stall), .tx_valid(tx_valid),
    .tx_byte(tx_byte), .tx_last(tx_last), .req_valid(req_valid),
    .req(req), .tx_ready(tx_ready));

  // Free-running clock
  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end

  // Verdict and end of run
  task automatic complete_run;
    $display("checks %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : complete_run

  // Single comparison point
  task automatic check(input string what, input logic [15:0] seen,
      input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // Compare gathered bytes against an image cut to the asked length
  task automatic check_bytes(input string what, input byte_q_t exp,
      input int len);
    int n;
    n = (len < exp.size()) ? len : exp.size();
    check({what, " count"}, 16'(host_model_inst.got.size()), 16'(n));
    for (int i = 0; i < n && i < host_model_inst.got.size(); i++) begin
      check($sformatf("%s byte %0d", what, i), {8'h00,
        host_model_inst.got[i]}, {8'h00, exp[i]});
    end
  endtask : check_bytes

  // Device descriptor image
  function automatic byte_q_t dev_exp(input logic [15:0] vid,
      input logic [15:0] pid);
    dev_exp = '{8'h12, 8'h01, 8'h00, 8'h02, 8'h00, 8'h00, 8'h00, 8'h08,
      vid[7:0], vid[15:8], pid[7:0], pid[15:8], 8'h01, 8'h01, 8'h01,
      8'h02, 8'h03, 8'h01};
  endfunction : dev_exp

  // Configuration set image: config, interface, three endpoints
  function automatic byte_q_t cfg_exp(input logic [7:0] attr,
      input logic [7:0] pwr, input logic [15:0] mps, input logic [7:0] iv);
    cfg_exp = '{8'h09, 8'h02, 8'h27, 8'h00, 8'h01, 8'h01, 8'h00, attr, pwr,
      8'h09, 8'h04, 8'h00, 8'h00, 8'h03, 8'h00, 8'h00, 8'h00, 8'h00,
      8'h07, 8'h05, 8'h81, 8'h02, mps[7:0], mps[15:8], iv,
      8'h07, 8'h05, 8'h02, 8'h02, mps[7:0], mps[15:8], iv,
      8'h07, 8'h05, 8'h83, 8'h03, 8'h08, 8'h00, 8'h01};
  endfunction : cfg_exp

  // Set the live inputs on a clock edge
  task automatic set_env(input logic hs, input logic [7:0] ncr,
      input logic pr, input logic [15:0] vid, input logic [15:0] pid,
      input logic [7:0] pwr, input logic [7:0] iv);
    @(posedge clock);
    high_speed <= hs;
    network_control_reg <= ncr;
    eeprom <= '{present: pr, vendor_id: vid, product_id: pid,
      max_power: pwr, bulk_interval: iv};
  endtask : set_env

  // One fetch with its timeout handled
  task automatic run_fetch(input logic [7:0] t, input logic [7:0] idx,
      input logic [15:0] len, input logic slow);
    host_model_inst.fetch(t, idx, len, slow);
    if (host_model_inst.timed_out === 1'b1) begin
      num_errors++;
      $display("CHECK FAILED wait expected done seen timeout");
      complete_run();
    end
  endtask : run_fetch

  // Defaults used while no memory is present, junk on its fields
  task automatic t_device_default;
    set_env(1'b0, 8'h00, 1'b0, 16'h5A5A, 16'hA5A5, 8'hFF, 8'h77);
    run_fetch(8'h01, 8'h00, 16'h0040, 1'b0);
    check_bytes("device", dev_exp(16'h1111, 16'h2222), 64);
    $display("test device_default done");
  endtask : t_device_default

  // Memory identifiers, short request, slow consumer
  task automatic t_device_eeprom;
    set_env(1'b1, 8'hFF, 1'b1, 16'h3456, 16'h789A, 8'h64, 8'h05);
    run_fetch(8'h01, 8'h00, 16'h000A, 1'b1);
    check_bytes("device short", dev_exp(16'h3456, 16'h789A), 10);
    $display("test device_eeprom done");
  endtask : t_device_eeprom

  // Full speed, wake set, whole set then config alone back to back
  task automatic t_config_full;
    set_env(1'b0, 8'h40, 1'b0, 16'h0000, 16'h0000, 8'h11, 8'h22);
    run_fetch(8'h02, 8'h00, 16'h00FF, 1'b0);
    check_bytes("config fs", cfg_exp(8'hA0, 8'h3C, 16'h0040, 8'h00), 255);
    run_fetch(8'h02, 8'h00, 16'h0009, 1'b1);
    check_bytes("config only", cfg_exp(8'hA0, 8'h3C, 16'h0040, 8'h00), 9);
    $display("test config_full done");
  endtask : t_config_full

  // High speed, wake clear with other bits set, memory power and interval
  task automatic t_config_eeprom;
    set_env(1'b1, 8'hBF, 1'b1, 16'h0000, 16'h0000, 8'h64, 8'h05);
    run_fetch(8'h02, 8'h00, 16'h0027, 1'b1);
    check_bytes("config hs", cfg_exp(8'h80, 8'h64, 16'h0200, 8'h05), 39);
    $display("test config_eeprom done");
  endtask : t_config_eeprom

  // Clock enable toggled each cycle for the first 40 cycles of a whole set fetch
  task automatic t_ce_freeze;
    set_env(1'b0, 8'h00, 1'b0, 16'h0000, 16'h0000, 8'h11, 8'h22);
    fork
      run_fetch(8'h02, 8'h00, 16'h0027, 1'b0);
      begin
        repeat (40) begin
          @(posedge clock);
          ce <= ~ce;
        end
        @(posedge clock);
        ce <= 1'b1;
      end
    join
    check_bytes("config ce", cfg_exp(8'h80, 8'h3C, 16'h0040, 8'h00), 39);
    $display("test ce_freeze done");
  endtask : t_ce_freeze

  // Reset in mid-run clears outputs; ready returns one edge late
  task automatic t_reset_mid;
    @(posedge clock);
    sys_rst <= 1'b1;
    @(posedge clock);
    sys_rst <= 1'b0;
    check("reset ready", {15'h0000, req_ready}, 16'h0000);
    check("reset valid", {15'h0000, tx_valid}, 16'h0000);
    check("reset last", {15'h0000, tx_last}, 16'h0000);
    check("reset byte", {8'h00, tx_byte}, 16'h0000);
    @(posedge clock);
    check("ready at release", {15'h0000, req_ready}, 16'h0000);
    @(posedge clock);
    check("ready back", {15'h0000, req_ready}, 16'h0001);
    run_fetch(8'h01, 8'h00, 16'h0012, 1'b0);
    check_bytes("device reset", dev_exp(16'h1111, 16'h2222), 18);
    $display("test reset_mid done");
  endtask : t_reset_mid

  // Unsupported types and indices refused; zero length sends nothing
  task automatic t_refused;
    logic [15:0] reqs[5] = '{16'h0300, 16'h0400, 16'h0500, 16'h0101,
      16'h0201};
    foreach (reqs[i]) begin
      run_fetch(reqs[i][15:8], reqs[i][7:0], 16'h0012, 1'b0);
      check("stall", {15'h0000, host_model_inst.stalled}, 16'h0001);
      check("stall count", 16'(host_model_inst.got.size()), 16'h0000);
    end
    run_fetch(8'h01, 8'h00, 16'h0000, 1'b0);
    check("zero stall", {15'h0000, host_model_inst.stalled}, 16'h0000);
    check("zero count", 16'(host_model_inst.got.size()), 16'h0000);
    $display("test refused done");
  endtask : t_refused

  // Main sequence
  initial begin
    sys_rst = 1'b1;
    ce = 1'b1;
    high_speed = 1'b0;
    network_control_reg = 8'h00;
    eeprom = '0;
    repeat (2) @(posedge clock);
    sys_rst <= 1'b0;
    t_device_default();
    t_device_eeprom();
    t_config_full();
    t_config_eeprom();
    t_ce_freeze();
    t_reset_mid();
    t_refused();
    complete_run();
  end
endmodule : testbench
